/* File: rtl/dmms_datapath.sv */
// Dual multiply with parallel multiply-subtract datapath, top level.
// Function
// - Both operations complete in one issue slot.
// - Shared data word feeds both multipliers, sign-extended.
// - High coefficient on b2 bus, second multiplier.
// - Low coefficient at paired address, b bus.
// - Long word halves on c and d buses.
// - Unsigned qualifier zero-extends the operand.
// - Fractional mode shifts products left once.
// - Multiply saturation follows saturate_on_multiply.
// - Second product sign-extended to 40 bits.
// - First product subtracted from accumulator x.
// - Rounding qualifier rounds per rounding_method_select.
// - Overflow width per wide mode, flags set.
// - Overflowed destination saturates when enabled.
// - Wide qualifier forces wide mode for one instruction.
// - Coefficient step two, plain data step one.
// - Dual form: Y high, X low lane.
// - Signed dual data operands extend per sign_extension_mode.
// - Dual form unpaired; Y never addresses registers.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module dmms_datapath
  import dmms_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [REG_AW-1:0] reg_addr_i,
  input  wire logic [REG_DW-1:0] reg_wdata_i,
  input  wire logic              reg_write_i,
  input  wire logic              reg_read_i,
  output logic      [REG_DW-1:0] reg_rdata_o,
  input  wire logic              issue_i,
  input  wire dmms_instr_t       instr_i,
  input  wire logic              parallel_slot_i,
  output logic                   refused_o,
  output logic                   mem_read_o,
  output logic      [ADDR_W-1:0] x_addr_o,
  output logic      [ADDR_W-1:0] x_pair_addr_o,
  output logic      [ADDR_W-1:0] y_addr_o,
  output logic      [ADDR_W-1:0] coef_addr_o,
  output logic      [ADDR_W-1:0] coef_pair_addr_o,
  output logic                   ptr_update_o,
  output logic      [ADDR_W-1:0] x_ptr_o,
  output logic      [ADDR_W-1:0] y_ptr_o,
  output logic      [ADDR_W-1:0] coef_ptr_o,
  input  wire logic [DATA_W-1:0] c_data_bus_i,
  input  wire logic [DATA_W-1:0] d_data_bus_i,
  input  wire logic [DATA_W-1:0] b_data_bus_i,
  input  wire logic [DATA_W-1:0] b2_data_bus_i,
  input  wire logic [ACC_W-1:0]  accumulator_x_i,
  output logic                   result_valid_o,
  output logic      [ACC_W-1:0]  accumulator_x_o,
  output logic      [ACC_W-1:0]  accumulator_y_o,
  output logic                   overflow_flag_x_o,
  output logic                   overflow_flag_y_o
);

  // ==========================================================================
  // Declarations
  logic [5:0]        ctrl_reg;
  logic [5:0]        ctrl_next;
  logic [REG_DW-1:0] rdata_next;
  logic              ovf_x_next;
  logic              ovf_y_next;
  logic              clr_x;
  logic              clr_y;
  logic              refuse;
  logic              issue_ok;
  dmms_instr_t       instr_reg;
  dmms_instr_t       instr_next;
  logic              mem_read_next;
  logic              refused_next;
  logic [ADDR_W-1:0] x_addr_next;
  logic [ADDR_W-1:0] x_pair_next;
  logic [ADDR_W-1:0] y_addr_next;
  logic [ADDR_W-1:0] coef_addr_next;
  logic [ADDR_W-1:0] coef_pair_next;
  logic [ADDR_W-1:0] x_ptr_next;
  logic [ADDR_W-1:0] y_ptr_next;
  logic [ADDR_W-1:0] coef_ptr_next;
  dmms_mode_t        mode_eff;
  logic [DATA_W-1:0] lane_data [LANES];
  logic [DATA_W-1:0] lane_coef [LANES];
  logic              lane_duns [LANES];
  logic              lane_cuns [LANES];
  logic [ACC_W-1:0]  lane_acc  [LANES];
  logic [ACC_W-1:0]  lane_res  [LANES];
  logic              lane_ovf  [LANES];
  logic              data_sx;
  logic [ACC_W-1:0]  acc_x_next;
  logic [ACC_W-1:0]  acc_y_next;

  // Paired address of a long-word half: even goes up, odd goes down.
  function automatic logic [ADDR_W-1:0] pair_addr(
    input logic [ADDR_W-1:0] a
  );
    pair_addr = a[0] ? a - PAIR_STEP : a + PAIR_STEP;
  endfunction

  // ==========================================================================
  // Register port: control register and sticky overflow flags.
  always_comb begin
    ctrl_next  = ctrl_reg;
    rdata_next = '0;
    clr_x      = 1'b0;
    clr_y      = 1'b0;
    if (reg_write_i) begin
      if (reg_addr_i == CTRL_OFS) begin
        ctrl_next = reg_wdata_i[5:0];
      end else if (reg_addr_i == STATUS_OFS) begin
        clr_x = reg_wdata_i[ST_OVF_X];
        clr_y = reg_wdata_i[ST_OVF_Y];
      end
    end
    if (reg_read_i) begin
      if (reg_addr_i == CTRL_OFS) begin
        rdata_next = REG_DW'(ctrl_reg);
      end else if (reg_addr_i == STATUS_OFS) begin
        rdata_next = REG_DW'({overflow_flag_y_o, overflow_flag_x_o});
      end
    end
    // A new overflow wins over a clear in the same cycle.
    ovf_x_next = (overflow_flag_x_o && !clr_x) ||
                 (mem_read_o && lane_ovf[0]);
    ovf_y_next = (overflow_flag_y_o && !clr_y) ||
                 (mem_read_o && lane_ovf[1]);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ctrl_reg          <= CTRL_RESET;
      reg_rdata_o       <= '0;
      overflow_flag_x_o <= 1'b0;
      overflow_flag_y_o <= 1'b0;
    end else begin
      ctrl_reg          <= ctrl_next;
      reg_rdata_o       <= rdata_next;
      overflow_flag_x_o <= ovf_x_next;
      overflow_flag_y_o <= ovf_y_next;
    end
  end

  // ==========================================================================
  // Issue stage: address generation and pointer updates.
  always_comb begin
    // The dual form fills both slots and its Y side must miss registers.
    refuse = instr_i.form == FORM_DUAL &&
             (parallel_slot_i || instr_i.y_ptr < MMR_TOP);
    issue_ok       = issue_i && !refuse;
    refused_next   = issue_i && refuse;
    mem_read_next  = issue_ok;
    instr_next     = issue_ok ? instr_i : instr_reg;
    x_addr_next    = instr_i.x_ptr;
    x_pair_next    = pair_addr(instr_i.x_ptr);
    y_addr_next    = instr_i.y_ptr;
    coef_addr_next = instr_i.coef_ptr;
    coef_pair_next = pair_addr(instr_i.coef_ptr);
    coef_ptr_next  = instr_i.coef_ptr;
    x_ptr_next     = instr_i.x_ptr;
    y_ptr_next     = instr_i.y_ptr;
    if (instr_i.coef_inc) begin
      coef_ptr_next = instr_i.coef_ptr + HILO_STEP;
    end
    if (instr_i.x_dec) begin
      x_ptr_next = instr_i.x_ptr -
        (instr_i.form == FORM_LONG ? HILO_STEP : DATA_STEP);
    end
    if (instr_i.y_dec) begin
      y_ptr_next = instr_i.y_ptr - DATA_STEP;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      instr_reg        <= '0;
      mem_read_o       <= 1'b0;
      refused_o        <= 1'b0;
      ptr_update_o     <= 1'b0;
      x_addr_o         <= '0;
      x_pair_addr_o    <= '0;
      y_addr_o         <= '0;
      coef_addr_o      <= '0;
      coef_pair_addr_o <= '0;
      x_ptr_o          <= '0;
      y_ptr_o          <= '0;
      coef_ptr_o       <= '0;
    end else begin
      instr_reg        <= instr_next;
      mem_read_o       <= mem_read_next;
      refused_o        <= refused_next;
      ptr_update_o     <= mem_read_next;
      x_addr_o         <= x_addr_next;
      x_pair_addr_o    <= x_pair_next;
      y_addr_o         <= y_addr_next;
      coef_addr_o      <= coef_addr_next;
      coef_pair_addr_o <= coef_pair_next;
      x_ptr_o          <= x_ptr_next;
      y_ptr_o          <= y_ptr_next;
      coef_ptr_o       <= coef_ptr_next;
    end
  end

  // ==========================================================================
  // Operand routing: lane 1 is the second multiplier, lane 0 the first.
  always_comb begin
    mode_eff = dmms_mode_t'(ctrl_reg);
    mode_eff.wide_overflow_mode = ctrl_reg[4] || instr_reg.q40;
    data_sx  = instr_reg.form == FORM_DUAL ?
               mode_eff.sign_extension_mode : 1'b1;
    lane_data[1] = d_data_bus_i;
    if (instr_reg.form != FORM_SINGLE) begin
      lane_data[1] = c_data_bus_i;
    end
    lane_data[0] = d_data_bus_i;
    lane_coef[1] = b2_data_bus_i;
    lane_coef[0] = b_data_bus_i;
    lane_duns[1] = instr_reg.uns_data_hi;
    lane_duns[0] = instr_reg.uns_data_lo;
    lane_cuns[1] = instr_reg.uns_coef_hi;
    lane_cuns[0] = instr_reg.uns_coef_lo;
    lane_acc[1]  = '0;
    lane_acc[0]  = accumulator_x_i;
  end

  // Both lanes evaluate in the same cycle.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    dmms_mac_lane u_lane (
      .data_i     (lane_data[g]),
      .coef_i     (lane_coef[g]),
      .data_uns_i (lane_duns[g]),
      .data_sx_i  (data_sx),
      .coef_uns_i (lane_cuns[g]),
      .mode_i     (mode_eff),
      .rnd_i      (instr_reg.rnd),
      .sub_i      (g == 0),
      .acc_i      (lane_acc[g]),
      .result_o   (lane_res[g]),
      .ovf_o      (lane_ovf[g])
    );
  end

  // ==========================================================================
  // Result stage: both accumulators written together.
  always_comb begin
    acc_x_next = accumulator_x_o;
    acc_y_next = accumulator_y_o;
    if (mem_read_o) begin
      acc_x_next = lane_res[0];
      acc_y_next = lane_res[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      result_valid_o  <= 1'b0;
      accumulator_x_o <= '0;
      accumulator_y_o <= '0;
    end else begin
      result_valid_o  <= mem_read_o;
      accumulator_x_o <= acc_x_next;
      accumulator_y_o <= acc_y_next;
    end
  end

  // ==========================================================================
  // Assertions and covers.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  a_issue_reads: assert property (
    issue_ok |=> mem_read_o && ptr_update_o)
    else $error("accepted issue did not fetch operands");

  a_result_next: assert property (
    mem_read_o |=> result_valid_o)
    else $error("result not written one cycle after fetch");

  a_coef_pair: assert property (
    mem_read_o |-> (coef_pair_addr_o ^ coef_addr_o) == PAIR_STEP)
    else $error("low coefficient address is not the pair");

  a_coef_step: assert property (
    issue_ok && instr_i.coef_inc |=>
      coef_ptr_o == $past(instr_i.coef_ptr) + HILO_STEP)
    else $error("coefficient pointer did not advance by two");

  a_data_step: assert property (
    issue_ok && instr_i.x_dec && instr_i.form == FORM_SINGLE |=>
      x_ptr_o == $past(instr_i.x_ptr) - DATA_STEP)
    else $error("plain data decrement is not one");

  a_flag_set: assert property (
    mem_read_o && lane_ovf[0] |=> overflow_flag_x_o ##1
      (overflow_flag_x_o || $past(clr_x)))
    else $error("x overflow flag not set or lost");

  a_flag_hold: assert property (
    overflow_flag_y_o && !clr_y |=> overflow_flag_y_o)
    else $error("y overflow flag dropped without a clear");

  a_sat_value: assert property (
    mem_read_o && lane_ovf[0] && mode_eff.datapath_saturation &&
    !mode_eff.wide_overflow_mode |=>
      accumulator_x_o == SAT32_POS || accumulator_x_o == SAT32_NEG)
    else $error("overflowed x accumulator not saturated");

  a_wide_local: assert property (
    mem_read_o && instr_reg.q40 && !reg_write_i |=> $stable(ctrl_reg))
    else $error("wide qualifier changed the stored mode");

  a_dual_refuse: assert property (
    issue_i && instr_i.form == FORM_DUAL && parallel_slot_i |=>
      refused_o && !mem_read_o)
    else $error("paired dual form was not refused");

  c_single: cover property (issue_ok && instr_i.form == FORM_SINGLE);
  c_long:   cover property (issue_ok && instr_i.form == FORM_LONG);
  c_dual:   cover property (issue_ok && instr_i.form == FORM_DUAL);
  c_ovf:    cover property (mem_read_o && lane_ovf[0] && lane_ovf[1]);

endmodule

/* File: rtl/dmms_pkg.sv */
// Constants and types shared by the dual multiply-subtract datapath.
package dmms_pkg;

  // ==========================================================================
  // Widths
  localparam int DATA_W  = 16;
  localparam int EXT_W   = 17;
  localparam int PROD_W  = 34;
  localparam int ACC_W   = 40;
  localparam int ADDR_W  = 23;
  localparam int REG_AW  = 8;
  localparam int REG_DW  = 16;
  localparam int LANES   = 2;
  localparam int SIGN32  = 31;

  // ==========================================================================
  // Register map and reset values
  localparam logic [REG_AW-1:0] CTRL_OFS   = 8'h00;
  localparam logic [REG_AW-1:0] STATUS_OFS = 8'h01;
  localparam logic [5:0]        CTRL_RESET = 6'h20;
  localparam int                ST_OVF_X   = 0;
  localparam int                ST_OVF_Y   = 1;

  // ==========================================================================
  // Address generation constants
  localparam logic [ADDR_W-1:0] DATA_STEP = 23'h000001;
  localparam logic [ADDR_W-1:0] HILO_STEP = 23'h000002;
  localparam logic [ADDR_W-1:0] PAIR_STEP = 23'h000001;
  localparam logic [ADDR_W-1:0] MMR_TOP   = 23'h000060;

  // ==========================================================================
  // Arithmetic constants; ROUND_HALF, ROUND_MASK and MULT_SAT at the 41-bit working width
  localparam logic [ACC_W:0]   ROUND_HALF = 41'h00000008000;
  localparam logic [ACC_W:0]   ROUND_MASK = 41'h1ffffff0000;
  localparam logic [15:0]      HALF_LSB   = 16'h8000;
  localparam logic [ACC_W-1:0] SAT40_POS  = 40'h7fffffffff;
  localparam logic [ACC_W-1:0] SAT40_NEG  = 40'h8000000000;
  localparam logic [ACC_W-1:0] SAT32_POS  = 40'h007fffffff;
  localparam logic [ACC_W-1:0] SAT32_NEG  = 40'hff80000000;
  localparam logic [ACC_W:0]   MULT_SAT   = 41'h0007fffffff;
  localparam logic [EXT_W-1:0] MIN_OPND   = 17'h18000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    FORM_SINGLE,
    FORM_LONG,
    FORM_DUAL
  } dmms_form_t;

  // Control register layout, most significant field first.
  typedef struct packed {
    logic sign_extension_mode;
    logic wide_overflow_mode;
    logic datapath_saturation;
    logic rounding_method_select;
    logic saturate_on_multiply;
    logic fractional_mode;
  } dmms_mode_t;

  typedef struct packed {
    dmms_form_t        form;
    logic              rnd;
    logic              q40;
    logic              uns_data_hi;
    logic              uns_coef_hi;
    logic              uns_data_lo;
    logic              uns_coef_lo;
    logic              coef_inc;
    logic              x_dec;
    logic              y_dec;
    logic [ADDR_W-1:0] x_ptr;
    logic [ADDR_W-1:0] y_ptr;
    logic [ADDR_W-1:0] coef_ptr;
  } dmms_instr_t;

endpackage

/* File: rtl/dmms_mac_lane.sv */
// One multiplier lane: extend, multiply, scale, accumulate, round, saturate.
`timescale 1ns/1ps
module dmms_mac_lane
  import dmms_pkg::*;
(
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic [DATA_W-1:0] coef_i,
  input  wire logic              data_uns_i,
  input  wire logic              data_sx_i,
  input  wire logic              coef_uns_i,
  input  wire dmms_mode_t        mode_i,
  input  wire logic              rnd_i,
  input  wire logic              sub_i,
  input  wire logic [ACC_W-1:0]  acc_i,
  output logic      [ACC_W-1:0]  result_o,
  output logic                   ovf_o
);

  logic signed [EXT_W-1:0]  a_ext;
  logic signed [EXT_W-1:0]  b_ext;
  logic signed [PROD_W-1:0] prod;
  logic signed [ACC_W:0]    prod_ext;
  logic signed [ACC_W:0]    acc_ext;
  logic        [ACC_W:0]    sum;
  logic        [ACC_W:0]    rounded;
  logic                     bump;

  // ==========================================================================
  // Datapath of the lane, evaluated in a single cycle.
  always_comb begin
    // Zero extension wins over sign extension when the operand is unsigned.
    if (data_uns_i || !data_sx_i) begin
      a_ext = {1'b0, data_i};
    end else begin
      a_ext = {data_i[DATA_W-1], data_i};
    end
    if (coef_uns_i) begin
      b_ext = {1'b0, coef_i};
    end else begin
      b_ext = {coef_i[DATA_W-1], coef_i};
    end
    prod     = a_ext * b_ext;
    prod_ext = (ACC_W+1)'(prod);
    if (mode_i.fractional_mode) begin
      prod_ext = prod_ext <<< 1;
    end
    // Two most negative operands in fractional mode would give +1.0.
    if (mode_i.saturate_on_multiply && mode_i.fractional_mode &&
        a_ext == MIN_OPND && b_ext == MIN_OPND) begin
      prod_ext = MULT_SAT;
    end
    acc_ext = (ACC_W+1)'($signed(acc_i));
    if (sub_i) begin
      sum = acc_ext - prod_ext;
    end else begin
      sum = acc_ext + prod_ext;
    end
    // Unbiased rounding leaves an exact half alone when bit 16 is clear.
    bump = 1'b1;
    if (mode_i.rounding_method_select) begin
      bump = (sum[15:0] > HALF_LSB) ||
             (sum[15:0] == HALF_LSB && sum[DATA_W]);
    end
    rounded = sum;
    if (rnd_i) begin
      rounded = (bump ? sum + ROUND_HALF : sum) & ROUND_MASK;
    end
    if (mode_i.wide_overflow_mode) begin
      ovf_o = rounded[ACC_W] != rounded[ACC_W-1];
    end else begin
      ovf_o = rounded[ACC_W:SIGN32] != {(ACC_W-SIGN32+1){rounded[ACC_W]}};
    end
    result_o = rounded[ACC_W-1:0];
    if (ovf_o && mode_i.datapath_saturation) begin
      if (mode_i.wide_overflow_mode) begin
        result_o = rounded[ACC_W] ? SAT40_NEG : SAT40_POS;
      end else begin
        result_o = rounded[ACC_W] ? SAT32_NEG : SAT32_POS;
      end
    end
  end

endmodule

/* File: tb/dmms_mem_model.sv */
// Behavioural operand memories that answer the datapath's fetch cycles.
`timescale 1ns/1ps
module dmms_mem_model
  import dmms_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              issue_i,
  input  wire dmms_form_t        form_i,
  input  wire logic              mem_read_i,
  input  wire logic [ADDR_W-1:0] x_addr_i,
  input  wire logic [ADDR_W-1:0] x_pair_addr_i,
  input  wire logic [ADDR_W-1:0] y_addr_i,
  input  wire logic [ADDR_W-1:0] coef_addr_i,
  input  wire logic [ADDR_W-1:0] coef_pair_addr_i,
  output logic      [DATA_W-1:0] c_data_bus_o,
  output logic      [DATA_W-1:0] d_data_bus_o,
  output logic      [DATA_W-1:0] b_data_bus_o,
  output logic      [DATA_W-1:0] b2_data_bus_o
);
  // ==========================================================================
  // Storage
  // Data words, indexed by the low address byte.
  logic [DATA_W-1:0]   dmem [256];
  // Coefficients sit in internal storage only.
  logic [DATA_W-1:0]   cmem [256];
  dmms_form_t          form_reg;
  logic [4*DATA_W-1:0] last_reg;

  // ==========================================================================
  // Fetch
  // Keeps the form of the issue being fetched and the last bus values.
  always_ff @(posedge clk_i) begin
    if (issue_i) begin
      form_reg <= form_i;
    end
    if (mem_read_i) begin
      last_reg <= {c_data_bus_o, d_data_bus_o, b_data_bus_o, b2_data_bus_o};
    end
  end

  // Buses hold data only in the fetch cycle, inverted leftovers otherwise.
  always_comb begin
    {c_data_bus_o, d_data_bus_o, b_data_bus_o, b2_data_bus_o} = ~last_reg;
    if (mem_read_i) begin
      d_data_bus_o  = dmem[(form_reg == FORM_LONG) ? x_pair_addr_i[7:0]
                                                   : x_addr_i[7:0]];
      c_data_bus_o  = dmem[(form_reg == FORM_DUAL) ? y_addr_i[7:0]
                                                   : x_addr_i[7:0]];
      b_data_bus_o  = cmem[coef_pair_addr_i[7:0]];
      b2_data_bus_o = cmem[coef_addr_i[7:0]];
    end
  end
endmodule

/* File: tb/dual_mac_multiply_subtract_tb_top.sv */
// Self-checking bench for the dual multiply-subtract datapath.
`timescale 1ns/1ps
module dual_mac_multiply_subtract_tb_top
  import dmms_pkg::*;
;
  logic              clk_i, reset_i, reg_write_i, reg_read_i, issue_i;
  logic              parallel_slot_i, refused_o, mem_read_o, ptr_update_o;
  logic              result_valid_o, overflow_flag_x_o, overflow_flag_y_o;
  logic [REG_AW-1:0] reg_addr_i;
  logic [REG_DW-1:0] reg_wdata_i, reg_rdata_o;
  dmms_instr_t       instr_i;
  logic [ADDR_W-1:0] x_addr_o, x_pair_addr_o, y_addr_o, coef_addr_o;
  logic [ADDR_W-1:0] coef_pair_addr_o, x_ptr_o, y_ptr_o, coef_ptr_o;
  logic [DATA_W-1:0] c_bus, d_bus, b_bus, b2_bus;
  logic [ACC_W-1:0]  accumulator_x_i, accumulator_x_o, accumulator_y_o;
  logic [5:0]        ctrl;
  logic              fx, fy;
  int                miscompares, tests_run;
  dmms_instr_t       in;

  dmms_datapath u_dmms_datapath (.clk_i(clk_i), .reset_i(reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .issue_i(issue_i), .instr_i(instr_i),
    .parallel_slot_i(parallel_slot_i), .refused_o(refused_o),
    .mem_read_o(mem_read_o), .x_addr_o(x_addr_o),
    .x_pair_addr_o(x_pair_addr_o), .y_addr_o(y_addr_o),
    .coef_addr_o(coef_addr_o), .coef_pair_addr_o(coef_pair_addr_o),
    .ptr_update_o(ptr_update_o), .x_ptr_o(x_ptr_o), .y_ptr_o(y_ptr_o),
    .coef_ptr_o(coef_ptr_o), .c_data_bus_i(c_bus), .d_data_bus_i(d_bus),
    .b_data_bus_i(b_bus), .b2_data_bus_i(b2_bus),
    .accumulator_x_i(accumulator_x_i), .result_valid_o(result_valid_o),
    .accumulator_x_o(accumulator_x_o), .accumulator_y_o(accumulator_y_o),
    .overflow_flag_x_o(overflow_flag_x_o),
    .overflow_flag_y_o(overflow_flag_y_o));

  dmms_mem_model u_dmms_mem_model (.clk_i(clk_i), .issue_i(issue_i),
    .form_i(instr_i.form), .mem_read_i(mem_read_o), .x_addr_i(x_addr_o),
    .x_pair_addr_i(x_pair_addr_o), .y_addr_i(y_addr_o),
    .coef_addr_i(coef_addr_o), .coef_pair_addr_i(coef_pair_addr_o),
    .c_data_bus_o(c_bus), .d_data_bus_o(d_bus), .b_data_bus_o(b_bus),
    .b2_data_bus_o(b2_bus));

  // ==========================================================================
  // Helpers
  // Compares one value and counts the outcome.
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Second word of a pair: the neighbour within the even-aligned couple.
  function automatic logic [22:0] pair(input logic [22:0] a);
    return a[0] ? a - 23'h1 : a + 23'h1;
  endfunction

  // Reference for one lane; returns the overflow bit above the result.
  function automatic logic [40:0] lane(input logic [15:0] d, c,
      input logic ud, sx, uc, sub, input logic [39:0] acc,
      input dmms_instr_t i);
    logic signed [16:0] de, ce;
    logic signed [40:0] p, s;
    logic               w, o;
    de = (ud || !sx) ? {1'b0, d} : {d[15], d};
    ce = uc ? {1'b0, c} : {c[15], c};
    p = de * ce;
    if (ctrl[0]) p = p <<< 1;
    if (ctrl[1] && ctrl[0] && de == MIN_OPND && ce == MIN_OPND) p = MULT_SAT;
    s = sub ? $signed({acc[39], acc}) - p : p;
    if (i.rnd && (!ctrl[2] || s[15:0] > HALF_LSB ||
        (s[15:0] == HALF_LSB && s[16]))) s = s + ROUND_HALF;
    if (i.rnd) s = s & ROUND_MASK;
    w = ctrl[4] || i.q40;
    o = w ? (s[40] != s[39]) : !(&s[40:31] || !(|s[40:31]));
    if (o && ctrl[3]) s = w ? (s[40] ? SAT40_NEG : SAT40_POS)
                            : (s[40] ? SAT32_NEG : SAT32_POS);
    return {o, s[39:0]};
  endfunction

  // Expected {x lane, y lane} for one issue from the model's memories.
  function automatic logic [81:0] exp_of(input dmms_instr_t i,
      input logic [39:0] acc);
    logic [15:0] dh, dl;
    logic        sx;
    sx = i.form != FORM_DUAL || ctrl[5];
    dh = u_dmms_mem_model.dmem[i.form == FORM_DUAL ? i.y_ptr[7:0]
                                                   : i.x_ptr[7:0]];
    dl = u_dmms_mem_model.dmem[i.form == FORM_LONG ? 8'(pair(i.x_ptr))
                                                   : i.x_ptr[7:0]];
    return {lane(dl, u_dmms_mem_model.cmem[8'(pair(i.coef_ptr))],
                 i.uns_data_lo, sx, i.uns_coef_lo, 1'b1, acc, i),
            lane(dh, u_dmms_mem_model.cmem[i.coef_ptr[7:0]], i.uns_data_hi,
                 sx, i.uns_coef_hi, 1'b0, 40'h0, i)};
  endfunction

  // Register bus write; the control copy follows.
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    if (a == CTRL_OFS) ctrl = d[5:0];
  endtask

  // Register bus read; data stands one cycle then returns to zero.
  task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk(reg_rdata_o, exp);
    @(posedge clk_i);
    #1;
    chk(reg_rdata_o, 16'h0);
  endtask

  // ==========================================================================
  // Scenarios
  // One issue: fetch addresses and pointers, then both results and flags.
  task automatic do_op(input dmms_instr_t i, input logic [39:0] acc);
    logic [81:0] e;
    e = exp_of(i, acc);
    @(posedge clk_i);
    issue_i         <= 1'b1;
    instr_i         <= i;
    accumulator_x_i <= acc;
    @(posedge clk_i);
    issue_i <= 1'b0;
    #1;
    chk(mem_read_o, 1'b1);
    chk(x_addr_o, i.x_ptr);
    chk(x_pair_addr_o, pair(i.x_ptr));
    chk(coef_addr_o, i.coef_ptr);
    chk(coef_pair_addr_o, pair(i.coef_ptr));
    if (i.form == FORM_DUAL) chk(y_addr_o, i.y_ptr);
    chk(ptr_update_o, 1'b1);
    chk(coef_ptr_o, i.coef_ptr + (i.coef_inc ? 23'h2 : 23'h0));
    chk(x_ptr_o, i.x_ptr - (i.x_dec ? ((i.form == FORM_LONG) ? 23'h2
                                       : 23'h1) : 23'h0));
    chk(y_ptr_o, i.y_ptr - {22'h0, i.y_dec});
    @(posedge clk_i);
    #1;
    fx = fx | e[81];
    fy = fy | e[40];
    chk(result_valid_o, 1'b1);
    chk(accumulator_x_o, e[80:41]);
    chk(accumulator_y_o, e[39:0]);
    chk(overflow_flag_x_o, fx);
    chk(overflow_flag_y_o, fy);
  endtask

  // A dual issue that must be turned away.
  task automatic refuse(input logic par, input logic [22:0] yp);
    in = '0;
    in.form = FORM_DUAL;
    in.y_ptr = yp;
    @(posedge clk_i);
    issue_i         <= 1'b1;
    instr_i         <= in;
    parallel_slot_i <= par;
    @(posedge clk_i);
    issue_i         <= 1'b0;
    parallel_slot_i <= 1'b0;
    #1;
    chk(refused_o, 1'b1);
    chk(mem_read_o, 1'b0);
    @(posedge clk_i);
    #1;
    chk(result_valid_o, 1'b0);
  endtask

  // Mode, form and qualifier sweep through a fixed table.
  task automatic sweep();
    logic [5:0]  ct [8] = '{6'h20, 6'h01, 6'h03, 6'h08, 6'h0c, 6'h1c,
                            6'h0b, 6'h00};
    logic [39:0] at [4] = '{40'h0, 40'h007fff8000, 40'h8000000000,
                            40'hff80000000};
    for (int i = 0; i < 24; i++) begin
      reg_wr(CTRL_OFS, {10'h0, ct[i%8]});
      in = '0;
      in.form = dmms_form_t'(i % 3);
      {in.q40, in.rnd, in.y_dec, in.x_dec, in.coef_inc} = i[4:0];
      {in.uns_data_hi, in.uns_coef_lo} = i[2] ? i[1:0] : 2'b00;
      in.x_ptr = 23'(32'h100 + i * 7);
      in.y_ptr = 23'(32'h80 + i);
      in.coef_ptr = 23'(i * 3);
      do_op(in, at[i%4]);
    end
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial begin
    #200000;
    miscompares++;
    conclude();
  end

  initial begin
    {reg_write_i, reg_read_i, issue_i, parallel_slot_i, fx, fy} = '0;
    {reg_addr_i, reg_wdata_i, instr_i, accumulator_x_i} = '0;
    miscompares = 0;
    tests_run = 0;
    ctrl = CTRL_RESET;
    reset_i = 1'b1;
    for (int k = 0; k < 256; k++) begin
      u_dmms_mem_model.dmem[k] = (k % 3 == 0) ? 16'h8000 : {k[7:0], ~k[7:0]};
      u_dmms_mem_model.cmem[k] = (k % 4 < 2) ? 16'h8000 : {~k[7:0], k[7:0]};
    end
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    reg_rd(CTRL_OFS, 16'h0020);
    reg_wr(CTRL_OFS, 16'hffff);
    reg_rd(CTRL_OFS, 16'h003f);
    reg_wr(8'h07, 16'h1234);
    reg_rd(8'h07, 16'h0000);
    sweep();
    reg_wr(CTRL_OFS, 16'h0020);
    u_dmms_mem_model.dmem[8'hff] = 16'hfe00;
    u_dmms_mem_model.cmem[8'h01] = 16'h4000;
    in = '0;
    {in.uns_data_hi, in.uns_coef_hi, in.uns_data_lo, in.uns_coef_lo} = '1;
    {in.coef_inc, in.x_dec, in.x_ptr, in.coef_ptr} = {2'b11, 23'h10ff,
                                                       23'h2000};
    do_op(in, 40'h0000008000);
    chk(accumulator_x_o, 40'hffc0808000);
    chk(accumulator_y_o, 40'h007f000000);
    in.form = FORM_DUAL;
    in.y_ptr = 23'h000060;
    do_op(in, 40'h0);
    refuse(1'b1, 23'h000200);
    refuse(1'b0, 23'h00005f);
    reg_rd(STATUS_OFS, {14'h0, fy, fx});
    reg_wr(STATUS_OFS, 16'h0003);
    fx = 1'b0;
    fy = 1'b0;
    reg_rd(STATUS_OFS, 16'h0000);
    conclude();
  end
endmodule
